/* File: common/piots_pkg.sv */
/*
  Shared constants and types for the two programmable rear-panel I/O pins.
  Assumes a single 25 MHz clock and no register bus: settings arrive as ports.
*/
package piots_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TRIG_LOW_US = 30;
  localparam int unsigned US_PER_S = 1_000_000;
  // A least time rounds up to whole cycles.
  localparam int unsigned TRIG_LOW_CYC = (TRIG_LOW_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] TRIG_LOW_CNT = CNT_W'(TRIG_LOW_CYC);
  localparam int unsigned PWM_W = 16;
  localparam logic [PWM_W-1:0] PWM_ZERO = 16'h0000;
  localparam logic [PWM_W-1:0] PWM_ONE = 16'h0001;

  typedef enum logic [1:0] {PIOTS_STATUS_FN, PIOTS_INPUT, PIOTS_OUTPUT} piots_mode_t;
  typedef enum logic [1:0] {PIOTS_OUT_TRUE, PIOTS_OUT_FALSE, PIOTS_OUT_PWM} piots_osel_t;
  typedef enum logic [1:0] {PIOTS_TGT_METER, PIOTS_TGT_DLOG, PIOTS_TGT_SEQ} piots_tgt_t;
  typedef enum logic {PIOTS_SRC_MANUAL, PIOTS_SRC_EXTERNAL} piots_src_t;
endpackage : piots_pkg

/* File: rtl/piots_top.sv */
/*
  Logic behind the status pin and the trigger pin: function select, polarity,
  general level input/output with PWM, trigger pulse out and trigger pulse in.
  Assumes pins are open-drain style tri-state pads resolved outside; settings
  are static ports from the instrument controller on the same clock.
*/
module piots_top
  import piots_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Instrument state and internal trigger.
  input wire logic out_switch_on,
  input wire logic int_trigger,
  // Status pin settings.
  input wire piots_pkg::piots_mode_t st_mode,
  input wire logic st_invert,
  input wire piots_pkg::piots_osel_t st_osel,
  input wire logic [piots_pkg::PWM_W-1:0] st_pwm_period,
  input wire logic [piots_pkg::PWM_W-1:0] st_pwm_high,
  // Trigger pin settings.
  input wire piots_pkg::piots_mode_t tr_mode,
  input wire logic tr_invert,
  input wire logic tr_dir_out,
  input wire piots_pkg::piots_tgt_t tr_target,
  input wire piots_pkg::piots_src_t sequence_trigger_source,
  input wire piots_pkg::piots_osel_t tr_osel,
  input wire logic [piots_pkg::PWM_W-1:0] tr_pwm_period,
  input wire logic [piots_pkg::PWM_W-1:0] tr_pwm_high,
  // Status pin pad.
  input wire logic st_pin_i,
  output logic st_pin_o,
  output logic st_pin_oe,
  // Trigger pin pad.
  input wire logic tr_pin_i,
  output logic tr_pin_o,
  output logic tr_pin_oe,
  // Results toward the instrument.
  output logic st_level_q,
  output logic tr_level_q,
  output logic start_meter,
  output logic start_dlog,
  output logic start_seq
);
  import piots_pkg::*;

  // Pin level for a logical value in general output mode: true is low.
  function automatic logic out_level(input piots_osel_t sel, input logic pwm, input logic inv);
    logic v;
    v = (sel == PIOTS_OUT_TRUE) ? 1'b1 : (sel == PIOTS_OUT_FALSE) ? 1'b0 : pwm;
    return ~v ^ inv;
  endfunction : out_level

  // Free-running PWM counter; output true while below the high count.
  function automatic logic [PWM_W-1:0] pwm_next(input logic [PWM_W-1:0] c,
                                                input logic [PWM_W-1:0] per);
    return (c + PWM_ONE >= per) ? PWM_ZERO : c + PWM_ONE;
  endfunction : pwm_next

  logic [PWM_W-1:0] st_pwm_q;
  logic [PWM_W-1:0] tr_pwm_q;
  logic st_sync1_q, st_sync2_q, tr_sync1_q, tr_sync2_q, tr_prev_q;
  logic [CNT_W-1:0] low_cnt_q;
  logic tr_edge;
  logic [2:0] tr_warm_q;
  logic [CNT_W-1:0] act_len_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_pwm_q <= PWM_ZERO;
      tr_pwm_q <= PWM_ZERO;
    end else begin
      st_pwm_q <= pwm_next(st_pwm_q, st_pwm_period);
      tr_pwm_q <= pwm_next(tr_pwm_q, tr_pwm_period);
    end
  end

  // Two-flop synchronisers for the pad inputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_sync1_q <= 1'b1;
      st_sync2_q <= 1'b1;
      tr_sync1_q <= 1'b1;
      tr_sync2_q <= 1'b1;
      tr_prev_q <= 1'b1;
    end else begin
      st_sync1_q <= st_pin_i;
      st_sync2_q <= st_sync1_q;
      tr_sync1_q <= tr_pin_i;
      tr_sync2_q <= tr_sync1_q;
      tr_prev_q <= tr_sync2_q ^ tr_invert;
    end
  end

  // Logical input levels: a low pad reads true unless inverted.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_level_q <= 1'b0;
      tr_level_q <= 1'b0;
    end else begin
      st_level_q <= ~(st_sync2_q ^ st_invert);
      tr_level_q <= ~(tr_sync2_q ^ tr_invert);
    end
  end

  // The edge detector waits until its history holds real pad samples, so that an
  // inverted pin resting at the pull-up level shows no false edge after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tr_warm_q <= 3'h0;
    end else begin
      tr_warm_q <= {tr_warm_q[1:0], 1'b1};
    end
  end

  // Active edge of a trigger pulse after polarity; the sender keeps it 30 us.
  assign tr_edge = tr_warm_q[2] && (tr_mode == PIOTS_STATUS_FN) && !tr_dir_out &&
                   tr_prev_q && !(tr_sync2_q ^ tr_invert);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_meter <= 1'b0;
      start_dlog <= 1'b0;
      start_seq <= 1'b0;
    end else begin
      start_meter <= tr_edge && (tr_target == PIOTS_TGT_METER);
      start_dlog <= tr_edge && (tr_target == PIOTS_TGT_DLOG);
      start_seq <= tr_edge && (tr_target == PIOTS_TGT_SEQ) &&
                   (sequence_trigger_source == PIOTS_SRC_EXTERNAL);
    end
  end

  // Outgoing trigger pulse: a retrigger during a pulse restarts the low time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q <= CNT_ZERO;
    end else if (tr_mode != PIOTS_STATUS_FN || !tr_dir_out) begin
      low_cnt_q <= CNT_ZERO;
    end else if (int_trigger) begin
      low_cnt_q <= TRIG_LOW_CNT;
    end else if (low_cnt_q != CNT_ZERO) begin
      low_cnt_q <= low_cnt_q - CNT_ONE;
    end
  end

  // Pad drive.
  always_comb begin
    case (st_mode)
      PIOTS_STATUS_FN: begin
        st_pin_oe = 1'b1;
        st_pin_o = ~out_switch_on ^ st_invert;
      end
      PIOTS_OUTPUT: begin
        st_pin_oe = 1'b1;
        st_pin_o = out_level(st_osel, st_pwm_q < st_pwm_high, st_invert);
      end
      default: begin
        st_pin_oe = 1'b0;
        st_pin_o = 1'b1;
      end
    endcase
    case (tr_mode)
      PIOTS_STATUS_FN: begin
        tr_pin_oe = tr_dir_out;
        tr_pin_o = (low_cnt_q == CNT_ZERO) ^ tr_invert;
      end
      PIOTS_OUTPUT: begin
        tr_pin_oe = 1'b1;
        tr_pin_o = out_level(tr_osel, tr_pwm_q < tr_pwm_high, tr_invert);
      end
      default: begin
        tr_pin_oe = 1'b0;
        tr_pin_o = 1'b1;
      end
    endcase
  end

  // Length of the active drive seen at the trigger pad, for the pulse width check.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_len_q <= CNT_ZERO;
    end else if (tr_mode == PIOTS_STATUS_FN && tr_dir_out && tr_pin_o == tr_invert) begin
      if (act_len_q != {CNT_W{1'b1}}) begin
        act_len_q <= act_len_q + CNT_ONE;
      end
    end else begin
      act_len_q <= CNT_ZERO;
    end
  end

  a_status_level: assert property (@(posedge clk) disable iff (!rst_n)
    st_mode == PIOTS_STATUS_FN |-> st_pin_oe && st_pin_o == (out_switch_on == st_invert))
    else $error("status pin level wrong");
  a_status_invert: assert property (@(posedge clk) disable iff (!rst_n)
    st_mode == PIOTS_STATUS_FN && st_invert && !out_switch_on |-> !st_pin_o)
    else $error("inverted status level wrong");
  a_out_true: assert property (@(posedge clk) disable iff (!rst_n)
    st_mode == PIOTS_OUTPUT && st_osel == PIOTS_OUT_TRUE |-> st_pin_o == st_invert)
    else $error("output true level wrong");
  a_pulse_start: assert property (@(posedge clk) disable iff (!rst_n)
    tr_mode == PIOTS_STATUS_FN && tr_dir_out && int_trigger |=> low_cnt_q == TRIG_LOW_CNT)
    else $error("trigger pulse not started");
  a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
    tr_mode == PIOTS_STATUS_FN && tr_dir_out &&
    act_len_q != CNT_ZERO && tr_pin_o != tr_invert
    |-> act_len_q >= TRIG_LOW_CNT)
    else $error("trigger pulse too short");
  a_seq_gated: assert property (@(posedge clk) disable iff (!rst_n)
    start_seq |-> $past(sequence_trigger_source) == PIOTS_SRC_EXTERNAL)
    else $error("sequence started without external source");
  a_one_target: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0({start_meter, start_dlog, start_seq}))
    else $error("more than one target started");
  a_input_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    st_mode == PIOTS_INPUT |-> !st_pin_oe)
    else $error("input mode drives pin");
  a_dir_in: assert property (@(posedge clk) disable iff (!rst_n)
    tr_mode == PIOTS_STATUS_FN && !tr_dir_out |-> !tr_pin_oe)
    else $error("trigger in drives pin");
  c_pulse_out: cover property (@(posedge clk) disable iff (!rst_n)
    tr_pin_oe && !tr_pin_o ##1 tr_pin_o);
  c_seq_start: cover property (@(posedge clk) disable iff (!rst_n) start_seq);
  c_meter_start: cover property (@(posedge clk) disable iff (!rst_n) start_meter);
  c_dlog_start: cover property (@(posedge clk) disable iff (!rst_n) start_dlog);
endmodule : piots_top

/* File: verif/piots_ext.sv */
/*
  Model of the external instrument on one pin.
  Assumes a pull-up on the pin and that tasks are called at the falling edge.
*/
module piots_ext (
  // Clock and pin pad.
  input wire logic clk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic lvl = 1'b1;
  // A pin that nobody drives floats to the pull-up level.
  assign pin_i = pin_oe ? pin_o : (drv ? lvl : 1'b1);
  task automatic hold(input logic l);
    drv = 1'b1;
    lvl = l;
  endtask : hold
  task automatic free();
    drv = 1'b0;
  endtask : free
  task automatic pulse(input logic act, input int cyc);
    hold(act);
    repeat (cyc) @(negedge clk);
    hold(~act);
  endtask : pulse
endmodule : piots_ext

/* File: verif/testbench.sv */
/*
  Self-checking bench for the status and trigger pin logic.
  Assumes the external instrument model stands on both pins.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import piots_pkg::*;
  logic clk = 0, rst_n = 0, sw = 0, itrig = 0, st_inv = 0, tr_inv = 0, dir_out = 1;
  piots_mode_t st_mode = PIOTS_STATUS_FN, tr_mode = PIOTS_STATUS_FN;
  piots_osel_t st_osel = PIOTS_OUT_TRUE, tr_osel = PIOTS_OUT_TRUE;
  piots_tgt_t tgt = PIOTS_TGT_METER;
  piots_src_t src = PIOTS_SRC_MANUAL;
  logic [PWM_W-1:0] per = 16'h0004, hi = 16'h0001;
  logic st_i, st_o, st_oe, tr_i, tr_o, tr_oe, st_lv, tr_lv, s_m, s_d, s_s, lv;
  int mismatches = 0, cmp_count = 0, n_m = 0, n_d = 0, n_s = 0, n, np;
  piots_top i_piots_top (.clk(clk), .rst_n(rst_n), .out_switch_on(sw), .int_trigger(itrig),
    .st_mode(st_mode), .st_invert(st_inv), .st_osel(st_osel), .st_pwm_period(per),
    .st_pwm_high(hi), .tr_mode(tr_mode), .tr_invert(tr_inv), .tr_dir_out(dir_out),
    .tr_target(tgt), .sequence_trigger_source(src), .tr_osel(tr_osel), .tr_pwm_period(per),
    .tr_pwm_high(hi), .st_pin_i(st_i), .st_pin_o(st_o), .st_pin_oe(st_oe), .tr_pin_i(tr_i),
    .tr_pin_o(tr_o), .tr_pin_oe(tr_oe), .st_level_q(st_lv), .tr_level_q(tr_lv),
    .start_meter(s_m), .start_dlog(s_d), .start_seq(s_s));
  piots_ext i_piots_ext_st (.clk(clk), .pin_o(st_o), .pin_oe(st_oe), .pin_i(st_i));
  piots_ext i_piots_ext_tr (.clk(clk), .pin_o(tr_o), .pin_oe(tr_oe), .pin_i(tr_i));
  initial forever #20 clk = ~clk;
  always @(negedge clk) begin
    n_m += (s_m === 1'b1);
    n_d += (s_d === 1'b1);
    n_s += (s_s === 1'b1);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // Pad level for a logical value: true pulls low unless inverted.
  function automatic logic pad_of(input logic truth, input logic inv);
    return ~truth ^ inv;
  endfunction : pad_of
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  initial begin
    void'($urandom(72));
    cyc(16);
    rst_n = 1;
    cyc(2);
    for (int k = 0; k < 16; k++) begin
      sw = 1'($urandom);
      {tr_inv, st_inv} = {k[2], k[0]};
      st_mode = k[3] ? PIOTS_OUTPUT : PIOTS_STATUS_FN;
      st_osel = k[1] ? PIOTS_OUT_FALSE : PIOTS_OUT_TRUE;
      tr_osel = st_osel;
      tr_mode = PIOTS_OUTPUT;
      cyc(1);
      chk(st_oe, 1'b1);
      chk(st_o, pad_of(k[3] ? ~k[1] : sw, st_inv));
      chk(tr_o, pad_of(~k[1], tr_inv));
    end
    tr_inv = 1'b0;
    st_inv = 1'b0;
    tr_osel = PIOTS_OUT_PWM;
    st_osel = PIOTS_OUT_PWM;
    hi = 16'(1 + $urandom % 3);
    cyc(2);
    n = 0;
    np = 0;
    repeat (8) begin
      n += (tr_o === 1'b0);
      np += (st_o === 1'b0);
      cyc(1);
    end
    chk(16'(n), 16'(2 * hi));
    chk(16'(np), 16'(2 * hi));
    st_mode = PIOTS_INPUT;
    tr_mode = PIOTS_INPUT;
    for (int k = 0; k < 8; k++) begin
      {lv, tr_inv, st_inv} = {1'($urandom), k[0], k[1]};
      i_piots_ext_tr.hold(lv);
      i_piots_ext_st.hold(~lv);
      cyc(4);
      chk(tr_oe, 1'b0);
      chk({st_lv, tr_lv}, {pad_of(~lv, st_inv), pad_of(lv, tr_inv)});
    end
    i_piots_ext_tr.free();
    tr_mode = PIOTS_STATUS_FN;
    for (int k = 0; k < 3; k++) begin
      {dir_out, tr_inv} = {~k[1], k[0]};
      cyc(2);
      itrig = 1;
      cyc(1);
      itrig = 0;
      n = 0;
      repeat (800) begin
        n += (tr_o === tr_inv && tr_oe === 1'b1);
        cyc(1);
      end
      chk(16'(n), k[1] ? 16'h0000 : 16'(TRIG_LOW_CYC));
    end
    for (int k = 0; k < 12; k++) begin
      tr_inv = k[0];
      tgt = piots_tgt_t'(2'((k / 2) % 3));
      src = piots_src_t'(k >= 6);
      i_piots_ext_tr.hold(~tr_inv);
      cyc(6);
      {n_m, n_d, n_s} = '0;
      i_piots_ext_tr.pulse(tr_inv, TRIG_LOW_CYC);
      cyc(8);
      chk(16'(n_m), 16'(tgt == PIOTS_TGT_METER));
      chk(16'(n_d), 16'(tgt == PIOTS_TGT_DLOG));
      chk(16'(n_s), 16'(tgt == PIOTS_TGT_SEQ && src == PIOTS_SRC_EXTERNAL));
    end
    close_out();
  end
endmodule : testbench
